// file: hdl/ifmt_cycle_count.v
// cycle-count lookup for one decoded instruction
`timescale 1ns/10ps
`default_nettype none
`include "ifmt_defs.vh"
module ifmt_cycle_count (
   input  wire [7:0] opcode_i,
   input  wire       double_i,
   input  wire       cond_true_i,
   input  wire       skip_dbl_i,
   output reg  [1:0] cycles_o
);
   always @* begin
      cycles_o = `IFMT_CYC_ONE;
      if (double_i) begin
         cycles_o = `IFMT_CYC_TWO;
      end else if (opcode_i[7:4] == `IFMT_NIB_SKIP) begin
         if (cond_true_i) begin
            cycles_o = skip_dbl_i ? `IFMT_CYC_THREE : `IFMT_CYC_TWO;
         end
      end else begin
         case (opcode_i)
            `IFMT_OPC_JUMP, `IFMT_OPC_INDJ, `IFMT_OPC_RETURN: begin
               cycles_o = `IFMT_CYC_TWO;
            end
            `IFMT_OPC_TAB_RD, `IFMT_OPC_TAB_WR, `IFMT_OPC_RETINT: begin
               cycles_o = `IFMT_CYC_THREE;
            end
            default: begin
               if (cond_true_i) begin
                  cycles_o = `IFMT_CYC_TWO;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// file: hdl/ifmt_decoder.v
// instruction format decoder: word pairing, operand fields, cycle count
`timescale 1ns/10ps
`default_nettype none
`include "ifmt_defs.vh"
module ifmt_decoder #(
   parameter WORD_W = `IFMT_WORD_W,
   parameter REG_W  = `IFMT_REG_W
) (
   input  wire              clock_i,
   input  wire              reset_i,
   input  wire              fetch_valid_i,
   input  wire [WORD_W-1:0] fetch_word_i,
   input  wire              cond_true_i,
   input  wire              skip_dbl_i,
   output reg               issue_o,
   output reg  [7:0]        opcode_o,
   output reg  [2:0]        op_class_o,
   output reg               is_nop_o,
   output reg  [WORD_W-1:0] ext_word_o,
   output reg  [12:0]       file_addr_o,
   output reg               dest_is_file_o,
   output reg  [REG_W-1:0]  base_source_reg_o,
   output reg  [REG_W-1:0]  second_source_reg_o,
   output reg               second_mod_o,
   output reg  [REG_W-1:0]  result_dest_reg_o,
   output reg  [2:0]        result_mod_o,
   output reg               has_result_o,
   output reg  [3:0]        bit_pos_o,
   output reg               bit_indirect_o,
   output reg               target_is_file_o,
   output reg  [11:0]       literal_o,
   output reg  [1:0]        cycles_o,
   output reg               pending_o
);
   localparam ST_FIRST  = 1'b0;
   localparam ST_SECOND = 1'b1;

   reg              state_r;
   reg              state_nxt;
   reg [WORD_W-1:0] held_r;
   reg [7:0]        dec_opc;
   reg              dec_issue;
   reg              dec_double;
   reg [2:0]        dec_class;
   wire [1:0]       cyc_w;

   function is_double_opc;
      input [7:0] opc;
      begin
         is_double_opc = (opc == `IFMT_OPC_GOTO) || (opc == `IFMT_OPC_CALL)
                         || (opc == `IFMT_OPC_DO);
      end
   endfunction

   function [2:0] class_of;
      input [7:0] opc;
      begin
         case (opc[7:4])
            `IFMT_NIB_LITMOV: class_of = `IFMT_CLS_LITMOV;
            `IFMT_NIB_WORK_A,
            `IFMT_NIB_WORK_B,
            `IFMT_NIB_WORK_C: class_of = `IFMT_CLS_WORK;
            `IFMT_NIB_LITALU: class_of = `IFMT_CLS_LITALU;
            `IFMT_NIB_BIT:    class_of = `IFMT_CLS_BIT;
            `IFMT_NIB_FILE:   class_of = `IFMT_CLS_FILE;
            default:          class_of = `IFMT_CLS_CTRL;
         endcase
      end
   endfunction

   always @* begin
      state_nxt  = state_r;
      dec_issue  = 1'b0;
      dec_double = 1'b0;
      dec_opc    = fetch_word_i[`IFMT_OPC_HI:`IFMT_OPC_LO];
      dec_class  = class_of(dec_opc);
      case (state_r)
         ST_FIRST: begin
            if (fetch_valid_i) begin
               if (is_double_opc(dec_opc)) begin
                  state_nxt = ST_SECOND;
               end else begin
                  dec_issue = 1'b1;
                  // orphan second word is a no-op
                  if (dec_opc == `IFMT_ZERO_OPC) begin
                     dec_class = `IFMT_CLS_NOP;
                  end
               end
            end
         end
         ST_SECOND: begin
            dec_opc   = held_r[`IFMT_OPC_HI:`IFMT_OPC_LO];
            dec_class = `IFMT_CLS_DOUBLE;
            if (fetch_valid_i) begin
               dec_issue  = 1'b1;
               dec_double = 1'b1;
               state_nxt  = ST_FIRST;
            end
         end
         default: begin
            state_nxt = ST_FIRST;
         end
      endcase
   end

   ifmt_cycle_count u_cyc (
      .opcode_i    (dec_opc),
      .double_i    (dec_double),
      .cond_true_i (cond_true_i && (dec_class != `IFMT_CLS_NOP)),
      .skip_dbl_i  (skip_dbl_i),
      .cycles_o    (cyc_w)
   );

   always @(posedge clock_i) begin
      if (reset_i) begin
         state_r             <= ST_FIRST;
         held_r              <= {WORD_W{1'b0}};
         issue_o             <= 1'b0;
         opcode_o            <= 8'h00;
         op_class_o          <= `IFMT_CLS_NOP;
         is_nop_o            <= 1'b0;
         ext_word_o          <= {WORD_W{1'b0}};
         file_addr_o         <= 13'h0000;
         dest_is_file_o      <= 1'b0;
         base_source_reg_o   <= {REG_W{1'b0}};
         second_source_reg_o <= {REG_W{1'b0}};
         second_mod_o        <= 1'b0;
         result_dest_reg_o   <= {REG_W{1'b0}};
         result_mod_o        <= 3'h0;
         has_result_o        <= 1'b0;
         bit_pos_o           <= 4'h0;
         bit_indirect_o      <= 1'b0;
         target_is_file_o    <= 1'b0;
         literal_o           <= 12'h000;
         cycles_o            <= `IFMT_CYC_ONE;
         pending_o           <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         pending_o <= (state_nxt == ST_SECOND);
         issue_o   <= dec_issue;
         if (state_r == ST_FIRST && fetch_valid_i) begin
            held_r <= fetch_word_i;
         end
         if (dec_issue) begin
            opcode_o   <= dec_opc;
            op_class_o <= dec_class;
            is_nop_o   <= (dec_class == `IFMT_CLS_NOP);
            cycles_o   <= cyc_w;
            // second word carries 16 payload bits; top byte is zero by encoding
            ext_word_o <= dec_double ? fetch_word_i : {WORD_W{1'b0}};
            file_addr_o    <= fetch_word_i[`IFMT_F_HI:`IFMT_F_LO];
            dest_is_file_o <= (dec_class == `IFMT_CLS_FILE)
                              && fetch_word_i[`IFMT_DSEL_BIT];
            base_source_reg_o   <= fetch_word_i[`IFMT_BASE_HI:`IFMT_BASE_LO];
            second_source_reg_o <= fetch_word_i[`IFMT_SRC2_HI:`IFMT_SRC2_LO];
            result_dest_reg_o   <= fetch_word_i[`IFMT_DST_HI:`IFMT_DST_LO];
            second_mod_o        <= (dec_class == `IFMT_CLS_WORK)
                                   && fetch_word_i[`IFMT_SRC2M_BIT];
            result_mod_o        <= fetch_word_i[`IFMT_DSTM_HI:`IFMT_DSTM_LO];
            bit_pos_o        <= fetch_word_i[`IFMT_BITPOS_HI:`IFMT_BITPOS_LO];
            bit_indirect_o   <= (dec_class == `IFMT_CLS_BIT)
                                && fetch_word_i[`IFMT_BITIND_BIT];
            target_is_file_o <= ((dec_class == `IFMT_CLS_BIT)
                                 || (dec_class == `IFMT_CLS_LITMOV))
                                && fetch_word_i[`IFMT_BITFILE_BIT];
            literal_o        <= fetch_word_i[`IFMT_LIT_HI:`IFMT_LIT_LO];
            // work class always has a result; literal ALU only when not back to source; others none
            case (dec_class)
               `IFMT_CLS_WORK:   has_result_o <= 1'b1;
               `IFMT_CLS_LITALU: has_result_o <= ~fetch_word_i[`IFMT_SAMEDST_BIT];
               default:          has_result_o <= 1'b0;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// file: shared/ifmt_defs.vh
// constants for the instruction format and timing decoder
`ifndef IFMT_DEFS_VH
`define IFMT_DEFS_VH
`define IFMT_WORD_W      24
`define IFMT_OPC_HI      23
`define IFMT_OPC_LO      16
`define IFMT_OPC_W       8
`define IFMT_ZERO_OPC    8'h00
// first words of the double-word instructions
`define IFMT_OPC_GOTO    8'h04
`define IFMT_OPC_CALL    8'h02
`define IFMT_OPC_DO      8'h08
// instruction classes
`define IFMT_CLS_NOP     3'h0
`define IFMT_CLS_FILE    3'h1
`define IFMT_CLS_WORK    3'h2
`define IFMT_CLS_BIT     3'h3
`define IFMT_CLS_LITMOV  3'h4
`define IFMT_CLS_LITALU  3'h5
`define IFMT_CLS_CTRL    3'h6
`define IFMT_CLS_DOUBLE  3'h7
// class selectors and the skip selector in the opcode top nibble
`define IFMT_NIB_LITMOV  4'h2
`define IFMT_NIB_WORK_A  4'h4
`define IFMT_NIB_WORK_B  4'h5
`define IFMT_NIB_WORK_C  4'h6
`define IFMT_NIB_LITALU  4'h7
`define IFMT_NIB_BIT     4'hA
`define IFMT_NIB_FILE    4'hB
`define IFMT_NIB_SKIP    4'hE
// control and table read/write opcodes that take extra cycles
`define IFMT_OPC_JUMP    8'h37
`define IFMT_OPC_INDJ    8'h01
`define IFMT_OPC_TAB_RD  8'hBA
`define IFMT_OPC_TAB_WR  8'hBB
`define IFMT_OPC_RETURN  8'h06
`define IFMT_OPC_RETINT  8'h07
// operand field positions
`define IFMT_F_HI        13
`define IFMT_F_LO        1
`define IFMT_DSEL_BIT    14
`define IFMT_BASE_HI     14
`define IFMT_BASE_LO     11
`define IFMT_DST_HI      10
`define IFMT_DST_LO      7
`define IFMT_DSTM_HI     6
`define IFMT_DSTM_LO     4
`define IFMT_SRC2_HI     3
`define IFMT_SRC2_LO     0
`define IFMT_SRC2M_BIT   15
`define IFMT_BITPOS_HI   15
`define IFMT_BITPOS_LO   12
`define IFMT_BITIND_BIT  11
`define IFMT_BITFILE_BIT 10
`define IFMT_LIT_HI      15
`define IFMT_LIT_LO      4
`define IFMT_SAMEDST_BIT 15
`define IFMT_REG_W       4
`define IFMT_CYC_W       2
`define IFMT_CYC_ONE     2'h1
`define IFMT_CYC_TWO     2'h2
`define IFMT_CYC_THREE   2'h3
`endif

// file: testbench/ifmt_decoder_bench.sv
// decoder bench: fetch model feeds words, tasks judge the decode
`timescale 1ns/10ps
`default_nettype none
module ifmt_decoder_bench;
   logic             clock_i = 1'b0;
   logic             reset_i = 1'b1;
   wire logic        fetch_valid_i, cond_true_i, skip_dbl_i, pending_o;
   wire logic [23:0] fetch_word_i, ext_word_o;
   wire logic        issue_o, is_nop_o, dest_is_file_o, second_mod_o, has_result_o;
   wire logic        bit_indirect_o, target_is_file_o;
   wire logic [7:0]  opcode_o;
   wire logic [2:0]  op_class_o, result_mod_o;
   wire logic [12:0] file_addr_o;
   wire logic [3:0]  base_source_reg_o, second_source_reg_o, result_dest_reg_o, bit_pos_o;
   wire logic [11:0] literal_o;
   wire logic [1:0]  cycles_o;
   int               fail_count = 0;
   int               checks = 0;
   always #10 clock_i = ~clock_i;
   ifmt_fetch_model u_mem (.clock_i, .fetch_valid_o(fetch_valid_i),
      .fetch_word_o(fetch_word_i), .cond_true_o(cond_true_i), .skip_dbl_o(skip_dbl_i));
   ifmt_decoder u_dut (.clock_i, .reset_i, .fetch_valid_i, .fetch_word_i, .cond_true_i,
      .skip_dbl_i, .issue_o, .opcode_o, .op_class_o, .is_nop_o, .ext_word_o, .file_addr_o,
      .dest_is_file_o, .base_source_reg_o, .second_source_reg_o, .second_mod_o,
      .result_dest_reg_o, .result_mod_o, .has_result_o, .bit_pos_o, .bit_indirect_o,
      .target_is_file_o, .literal_o, .cycles_o, .pending_o);
   task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic one(input logic [23:0] w, input logic c, input logic d, input logic [1:0] y);
      u_mem.put(w, c, d);
      u_mem.idle(1);
      chk("issue", {1'b1, w[23:16], y}, {issue_o, opcode_o, cycles_o});
   endtask
   task automatic t_file;
      one(24'hB14ABC, 1'b0, 1'b0, 2'h1);
      chk("file", {3'h1, 1'b1, 13'h055E}, {op_class_o, dest_is_file_o, file_addr_o});
      one(24'hB10ABC, 1'b1, 1'b0, 2'h2);
      chk("dest", 1'b0, dest_is_file_o);
   endtask
   task automatic t_work;
      logic [3:0] r;
      logic [3:0] rn;
      logic [3:0] nb [3] = '{4'h4, 4'h5, 4'h6};
      for (int i = 0; i < 16; i++) begin
         r = i[3:0];
         rn = ~r;
         // all three register-class nibbles are walked
         one({nb[i % 3], 4'h8, 1'b1, r, rn, 3'h5, r}, 1'b0, 1'b0, 2'h1);
         chk("regs", {r, r, rn},
            {base_source_reg_o, second_source_reg_o, result_dest_reg_o});
         chk("mods", {3'h2, 5'h1B},
            {op_class_o, second_mod_o, result_mod_o, has_result_o});
      end
   endtask
   task automatic t_bitlit;
      one(24'hA09C00, 1'b0, 1'b0, 2'h1);
      chk("bit", {3'h3, 4'h9, 2'h3},
         {op_class_o, bit_pos_o, bit_indirect_o, target_is_file_o});
      one(24'h205E30, 1'b0, 1'b0, 2'h1);
      chk("lmov", {3'h4, 1'b1, 12'h5E3}, {op_class_o, target_is_file_o, literal_o});
      one(24'h70B8A0, 1'b0, 1'b0, 2'h1);
      chk("lalu", {3'h5, 1'b0, 4'h7, 12'hB8A},
         {op_class_o, has_result_o, base_source_reg_o, literal_o});
      one(24'h7038A0, 1'b0, 1'b0, 2'h1);
      chk("has_res", 1'b1, has_result_o);
   endtask
   task automatic t_double;
      logic [7:0] f [3] = '{8'h04, 8'h02, 8'h08};
      for (int k = 0; k < 3; k++) begin
         u_mem.put({f[k], 16'h0000}, 1'b0, 1'b0);
         u_mem.idle(k);
         if (k > 0) chk("pend", 2'h2, {pending_o, issue_o});
         u_mem.put({12'h000, k[3:0], 8'h5A}, 1'b1, 1'b0);
         u_mem.idle(1);
         chk("pair", {1'b1, f[k], 3'h7, 2'h2},
            {issue_o, opcode_o, op_class_o, cycles_o});
         chk("ext", {12'h000, k[3:0], 8'h5A}, ext_word_o);
      end
      one(24'h00ABCD, 1'b1, 1'b0, 2'h1);
      chk("nop", 4'h8, {is_nop_o, op_class_o});
   endtask
   task automatic t_ctrl;
      logic [7:0] op [6] = '{8'h37, 8'h01, 8'hBA, 8'hBB, 8'h06, 8'h07};
      logic [1:0] ex [6] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h3};
      for (int k = 0; k < 6; k++) begin
         u_mem.put({op[k], 16'h0000}, 1'b0, 1'b0);
         u_mem.idle(1);
         chk("slow", 1'b1, cycles_o[1]);
         chk("cycles", ex[k], cycles_o);
      end
      for (int k = 0; k < 4; k++) begin
         one(24'hE00000, k[1], k[0], k[1] ? 2'h2 + k[0] : 2'h1);
         chk("skip_cls", 3'h6, op_class_o);
      end
   endtask
   task automatic t_reset;
      u_mem.put(24'h040000, 1'b0, 1'b0);
      u_mem.idle(1);
      reset_i <= 1'b1;
      @(negedge clock_i);
      reset_i <= 1'b0;
      chk("rst", 4'h1, {pending_o, issue_o, cycles_o});
      // a word after reset must not be merged with the dropped first word
      one(24'hB10000, 1'b0, 1'b0, 2'h1);
      chk("rst_cls", 3'h1, op_class_o);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clock_i);
      fail_count++;
      complete_run();
   end
   initial begin
      repeat (10) @(negedge clock_i);
      reset_i <= 1'b0;
      t_file();
      t_work();
      t_bitlit();
      t_double();
      t_ctrl();
      t_reset();
      complete_run();
   end
endmodule
`default_nettype wire

// file: testbench/ifmt_decoder_monitor.sv
// decoder port assertions
`timescale 1ns/10ps
`default_nettype none
module ifmt_decoder_monitor #(
   parameter WORD_W = 24
) (
   input wire logic              clock_i,
   input wire logic              reset_i,
   input wire logic              fetch_valid_i,
   input wire logic [WORD_W-1:0] fetch_word_i,
   input wire logic              cond_true_i,
   input wire logic              skip_dbl_i,
   input wire logic              issue_o,
   input wire logic [7:0]        opcode_o,
   input wire logic [2:0]        op_class_o,
   input wire logic              is_nop_o,
   input wire logic [WORD_W-1:0] ext_word_o,
   input wire logic [3:0]        base_source_reg_o,
   input wire logic [1:0]        cycles_o,
   input wire logic              pending_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   wire logic [7:0] opc   = fetch_word_i[WORD_W-1 -: 8];
   wire logic [3:0] base_f = fetch_word_i[14:11];
   wire logic       first = fetch_valid_i && !pending_o;
   wire logic       dbl   = opc == 8'h04 || opc == 8'h02 || opc == 8'h08;
   sequence s_first_word;
      first && dbl;
   endsequence
   sequence s_second_word;
      pending_o && fetch_valid_i;
   endsequence
   a_double_holds: assert property (s_first_word |=> pending_o && !issue_o)
      else $error("first word of a pair issued early");
   a_pair_merge: assert property (s_first_word ##1 s_second_word |=> issue_o &&
      op_class_o == 3'h7 && cycles_o == 2'h2 && ext_word_o == $past(fetch_word_i)
      && opcode_o == $past(opc, 2))
      else $error("pair not merged into one issue");
   a_single_issue: assert property (first && !dbl |=> issue_o && !pending_o
      && opcode_o == $past(opc))
      else $error("single word not issued next cycle");
   a_no_spurious: assert property (!fetch_valid_i |=> !issue_o)
      else $error("issue without a fetched word");
   // reset clears the fields, so the edge just after release is not a hold
   a_fields_hold: assert property (!issue_o && !$past(reset_i) |-> $stable(opcode_o) &&
      $stable(cycles_o) && $stable(ext_word_o))
      else $error("fields moved without issue");
   a_orphan_nop: assert property (first && opc == 8'h00 |=> is_nop_o &&
      op_class_o == 3'h0 && cycles_o == 2'h1)
      else $error("orphan second word not a no-op");
   a_skip_cycles: assert property (first && opc[7:4] == 4'hE |=> cycles_o ==
      ($past(cond_true_i) ? ($past(skip_dbl_i) ? 2'h3 : 2'h2) : 2'h1))
      else $error("skip cycle count wrong");
   a_work_cycles: assert property (first && opc[7:4] inside {4'h4, 4'h5, 4'h6} |=>
      cycles_o == ($past(cond_true_i) ? 2'h2 : 2'h1))
      else $error("single-word cycle count wrong");
   a_base_field: assert property (first && !dbl |=> base_source_reg_o == $past(base_f))
      else $error("base register field wrong");
   a_ctrl_cycles: assert property (first && (opc == 8'h37 || opc == 8'h01 ||
      opc == 8'hBA) |=> cycles_o[1])
      else $error("control op took one cycle");
endmodule
bind ifmt_decoder ifmt_decoder_monitor #(.WORD_W(WORD_W)) u_mon (.clock_i, .reset_i,
   .fetch_valid_i, .fetch_word_i, .cond_true_i, .skip_dbl_i, .issue_o, .opcode_o,
   .op_class_o, .is_nop_o, .ext_word_o, .base_source_reg_o, .cycles_o, .pending_o);
`default_nettype wire

// file: testbench/ifmt_fetch_model.sv
// program memory fetch path model
`timescale 1ns/10ps
`default_nettype none
module ifmt_fetch_model (
   input  wire logic        clock_i,
   output var  logic        fetch_valid_o = 1'b0,
   output var  logic [23:0] fetch_word_o = 24'h000000,
   output var  logic        cond_true_o = 1'b0,
   output var  logic        skip_dbl_o = 1'b0
);
   task automatic put(input logic [23:0] w, input logic c, input logic d);
      @(negedge clock_i);
      fetch_valid_o <= 1'b1;
      fetch_word_o  <= w;
      cond_true_o   <= c;
      skip_dbl_o    <= d;
   endtask
   // released bus shows the inverse after an odd number of idle cycles, and the stale word again after an even number
   task automatic idle(input int n);
      repeat (n) begin
         @(negedge clock_i);
         fetch_valid_o <= 1'b0;
         fetch_word_o  <= ~fetch_word_o;
         cond_true_o   <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire
